// [hw/ard_top.sv]
// ard_top: read-command decoder for log read by DMA and multiple-sector reads
// assumes: host command strobe and media word stream on aclk, host always
// accepts xfer words, registers reached over AXI4-Lite
//
// Functional notes
// - vendor log page at address D9h
// - byte 4 bit 0 flags cache backing
// - firmware version in bytes 16 to 31
// - 47h returns log content by DMA
// - log selector and page number from LBA
// - sectors delivered as 16-bit words
// - one interrupt per multiple block
// - 28-bit multiple read starts at LBA
// - 28-bit count zero means 256 sectors
// - 48-bit count zero means 65536 sectors
// - failure reports first unrecoverable sector LBA
// - error status: fault, sense, error bits
// - uncorrectable error stops at failing sector
`timescale 1ns/1ps
`default_nettype none
module ard_top import ard_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [7:0] s_axi_araddr,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	input wire logic host_cmd_valid,
	input wire logic [7:0] host_cmd_op,
	input wire logic [15:0] host_cmd_count,
	input wire logic [47:0] host_cmd_lba,
	input wire logic media_valid,
	input wire logic [15:0] media_word,
	input wire logic media_uncorr,
	input wire logic media_fault,
	output logic media_req,
	output logic [47:0] media_lba,
	output logic xfer_valid,
	output logic [15:0] xfer_word,
	output logic xfer_dma,
	output logic cmd_done,
	output logic [7:0] ata_status,
	output logic [7:0] ata_error,
	output logic [47:0] ata_lba_out,
	output logic irq
);
	ard_reg_if rb ();
	ard_axil_slave u_slave (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.rb(rb.master)
	);

	logic nonvolatile_cache_backed;
	logic [7:0] mult;
	logic [127:0] fw;
	logic [IRQ_W-1:0] irq_stat;
	logic [IRQ_W-1:0] irq_mask;
	ard_state_t state;
	ard_state_t next_state;
	logic [7:0] widx;
	logic [7:0] wcnt;
	logic [16:0] sect_left;
	logic [7:0] blk_cnt;
	logic [7:0] blk_lim;

	// register decode
	wire wr_ctrl = rb.wr_en && rb.wr_addr == REG_CTRL;
	wire wr_mult = rb.wr_en && rb.wr_addr == REG_MULT;
	wire wr_fw = rb.wr_en && rb.wr_addr[7:4] == REG_FW0[7:4] && rb.wr_addr[1:0] == 2'b00;
	wire wr_istat = rb.wr_en && rb.wr_addr == REG_IRQ_STAT;
	wire wr_imask = rb.wr_en && rb.wr_addr == REG_IRQ_MASK;
	wire wr_ro = rb.wr_addr == REG_STATE || rb.wr_addr == REG_LASTERR;
	assign rb.wr_err = !(wr_ctrl || wr_mult || wr_fw || wr_istat || wr_imask || wr_ro);
	wire [1:0] wr_fw_sel = rb.wr_addr[3:2];
	wire [1:0] rd_fw_sel = rb.rd_addr[3:2];
	wire rd_fw = rb.rd_addr[7:4] == REG_FW0[7:4] && rb.rd_addr[1:0] == 2'b00;
	wire [31:0] rd_fw_word = fw[{rd_fw_sel, 5'b00000} +: 32];
	wire [31:0] rd_state_word = {7'h00, sect_left, 6'h00, state};
	wire [31:0] rd_err_word = {16'h0000, ata_error, ata_status};
	assign rb.rd_data =
		rb.rd_addr == REG_CTRL ? {31'h0000_0000, nonvolatile_cache_backed} :
		rb.rd_addr == REG_MULT ? {24'h00_0000, mult} :
		rb.rd_addr == REG_STATE ? rd_state_word :
		rb.rd_addr == REG_LASTERR ? rd_err_word :
		rd_fw ? rd_fw_word :
		rb.rd_addr == REG_IRQ_STAT ? {29'h0000_0000, irq_stat} :
		rb.rd_addr == REG_IRQ_MASK ? {29'h0000_0000, irq_mask} : 32'h0000_0000;
	assign rb.rd_err = !(rb.rd_addr == REG_CTRL || rb.rd_addr == REG_MULT ||
		rb.rd_addr == REG_STATE || rb.rd_addr == REG_LASTERR || rd_fw ||
		rb.rd_addr == REG_IRQ_STAT || rb.rd_addr == REG_IRQ_MASK);

	function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return res;
	endfunction

	// command decode
	wire idle = state == ST_IDLE;
	wire take = host_cmd_valid && idle;
	wire is_log = host_cmd_op == OP_LOG_DMA;
	wire is_m28 = host_cmd_op == OP_RDMUL;
	wire is_m48 = host_cmd_op == OP_RDMUL_EXT;
	wire [7:0] log_sel = host_cmd_lba[LBA_LOGSEL_LSB +: 8];
	wire [15:0] log_page = {host_cmd_lba[LBA_PGHI_LSB +: 8], host_cmd_lba[LBA_PGLO_LSB +: 8]};
	// only page 0 of the D9h log exists, so a request for more blocks aborts
	wire log_ok = is_log && log_sel == LOG_ADDR_NAND && log_page == LOG_PAGE_ONLY &&
		host_cmd_count == LOG_BLOCKS;
	wire mul_ok = (is_m28 || is_m48) && mult != MULT_RST;
	wire [16:0] cnt28 = host_cmd_count[7:0] == 8'h00 ? SECT28_ZERO :
		{9'h000, host_cmd_count[7:0]};
	wire [16:0] cnt48 = host_cmd_count == 16'h0000 ? SECT48_ZERO :
		{1'b0, host_cmd_count};
	wire [47:0] lba28 = {20'h0_0000, host_cmd_lba[LBA28_W-1:0]};

	// transfer progress
	wire in_log = state == ST_LOG;
	wire sect_word = state == ST_SECT && media_valid;
	wire bad_word = sect_word && media_uncorr;
	wire good_word = sect_word && !media_uncorr;
	wire sect_end = good_word && wcnt == WORD_LAST;
	wire last_sect = sect_end && sect_left == 17'h00001;
	wire blk_end = sect_end && (blk_cnt == blk_lim || last_sect);
	wire log_end = in_log && widx == WORD_LAST;
	wire abort = take && !log_ok && !mul_ok;
	wire finish_ok = log_end || last_sect;
	wire fail = abort || bad_word;
	wire [IRQ_W-1:0] irq_ev = {fail, finish_ok || fail, blk_end};
	wire [IRQ_W-1:0] irq_clr = (wr_istat && rb.wr_strb[0]) ? rb.wr_data[IRQ_W-1:0] : '0;
	wire [7:0] fault_bit = media_fault ? STAT_DF : 8'h00;

	function automatic logic [7:0] log_byte(input logic [8:0] b);
		if (b == LOG_BYTE_CODE) return LOG_ADDR_NAND;
		if (b == LOG_BYTE_LEN_LO) return LOG_PAGE_LEN[7:0];
		if (b == LOG_BYTE_LEN_HI) return LOG_PAGE_LEN[15:8];
		if (b == LOG_BYTE_FLAGS) return 8'(nonvolatile_cache_backed) << FLAG_NVC_BIT;
		if (b >= LOG_BYTE_FW_FIRST && b <= LOG_BYTE_FW_LAST)
			return fw[{b[3:0], 3'b000} +: 8];
		return 8'h00;
	endfunction
	wire [15:0] log_word = {log_byte({widx, 1'b1}), log_byte({widx, 1'b0})};

	always_comb begin
		next_state = state;
		unique case (state)
			ST_IDLE: begin
				if (take && log_ok) begin
					next_state = ST_LOG;
				end else if (take && mul_ok) begin
					next_state = ST_SECT;
				end
			end
			ST_LOG: begin
				if (log_end) begin
					next_state = ST_IDLE;
				end
			end
			ST_SECT: begin
				if (bad_word || last_sect) begin
					next_state = ST_IDLE;
				end
			end
			default: next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			nonvolatile_cache_backed <= 1'b0;
			mult <= MULT_RST;
			fw <= FW_RST;
			irq_mask <= '0;
		end else begin
			if (wr_ctrl && rb.wr_strb[0]) begin
				nonvolatile_cache_backed <= rb.wr_data[0];
			end
			if (wr_mult && rb.wr_strb[0]) begin
				mult <= rb.wr_data[7:0];
			end
			if (wr_fw) begin
				fw[{wr_fw_sel, 5'b00000} +: 32] <= merge(fw[{wr_fw_sel, 5'b00000} +: 32],
					rb.wr_data, rb.wr_strb);
			end
			if (wr_imask && rb.wr_strb[0]) begin
				irq_mask <= rb.wr_data[IRQ_W-1:0];
			end
		end
	end

	// new events win over a same-cycle clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_stat <= '0;
			irq <= 1'b0;
		end else begin
			irq_stat <= (irq_stat & ~irq_clr) | irq_ev;
			irq <= |(irq_stat & irq_mask);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= ST_IDLE;
			media_req <= 1'b0;
			widx <= 8'h00;
			wcnt <= 8'h00;
			blk_cnt <= 8'h00;
			blk_lim <= 8'h00;
			sect_left <= 17'h00000;
			media_lba <= 48'h0000_0000_0000;
		end else begin
			state <= next_state;
			media_req <= next_state == ST_SECT;
			if (take) begin
				widx <= 8'h00;
				wcnt <= 8'h00;
				blk_cnt <= 8'h00;
				// latched so a mid-command MULT write cannot skew block edges
				blk_lim <= mult - 8'h01;
				sect_left <= is_m28 ? cnt28 : cnt48;
				media_lba <= is_m28 ? lba28 : host_cmd_lba;
			end else begin
				if (in_log) begin
					widx <= widx + 8'h01;
				end
				if (good_word) begin
					wcnt <= wcnt + 8'h01;
				end
				if (sect_end) begin
					media_lba <= media_lba + 48'h0000_0000_0001;
					sect_left <= sect_left - 17'h00001;
					blk_cnt <= blk_end ? 8'h00 : blk_cnt + 8'h01;
				end
			end
		end
	end

	// data words; bad words are never passed on
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			xfer_valid <= 1'b0;
			xfer_word <= 16'h0000;
			xfer_dma <= 1'b0;
		end else begin
			xfer_valid <= in_log || good_word;
			xfer_word <= in_log ? log_word : media_word;
			xfer_dma <= in_log;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cmd_done <= 1'b0;
			ata_status <= STAT_RST;
			ata_error <= 8'h00;
			ata_lba_out <= 48'h0000_0000_0000;
		end else begin
			cmd_done <= finish_ok || fail;
			if (take && !abort) begin
				ata_status <= STAT_BSY | STAT_DRQ;
			end else if (abort) begin
				ata_status <= STAT_RDY | STAT_ERR;
				ata_error <= ERR_ABRT;
			end else if (bad_word) begin
				ata_status <= STAT_RDY | STAT_ERR | STAT_SENSE | fault_bit;
				ata_error <= ERR_UNC;
				ata_lba_out <= media_lba;
			end else if (finish_ok) begin
				ata_status <= STAT_RDY;
				ata_error <= 8'h00;
			end
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence s_bad_word;
		state == ST_SECT && media_valid && media_uncorr;
	endsequence
	sequence s_good_word;
		state == ST_SECT && media_valid && !media_uncorr;
	endsequence
	sequence s_take_m28;
		host_cmd_valid && idle && host_cmd_op == OP_RDMUL && mult != MULT_RST;
	endsequence

	chk_log_page_code: assert property (in_log && widx == 8'h00 |=>
		xfer_valid && xfer_word == {LOG_ADDR_NAND, 8'h00}) else $error("log code wrong");
	chk_log_cache_flag: assert property (in_log && widx == 8'h02 |=>
		xfer_word == {8'h00, 7'h00, $past(nonvolatile_cache_backed)}) else $error("flag wrong");
	chk_log_fw_bytes: assert property (in_log && widx == 8'h08 |=>
		xfer_word == $past(fw[15:0])) else $error("fw bytes wrong");
	chk_log_dma_run: assert property (take && log_ok |=> in_log [*8] ##1
		xfer_dma && xfer_valid) else $error("log not sent by dma");
	chk_log_bad_select: assert property (take && is_log && log_sel != LOG_ADDR_NAND |=>
		cmd_done && (ata_error & ERR_ABRT) != 8'h00 && idle) else $error("bad log taken");
	chk_word_pass: assert property (s_good_word |=>
		xfer_valid && !xfer_dma && xfer_word == $past(media_word)) else $error("word lost");
	chk_block_irq: assert property (blk_end && !last_sect |=>
		irq_stat[IRQ_BLOCK] && !cmd_done) else $error("block irq missing");
	chk_first_lba: assert property (s_take_m28 |=>
		media_req && media_lba == {20'h0_0000, $past(host_cmd_lba[27:0])}) else $error("lba wrong");
	chk_count_256: assert property (s_take_m28 ##0 host_cmd_count[7:0] == 8'h00 |=>
		sect_left == 17'h00100) else $error("count 256 wrong");
	chk_count_65536: assert property (take && is_m48 && mul_ok &&
		host_cmd_count == 16'h0000 |=> sect_left == 17'h10000) else $error("count 65536 wrong");
	chk_fail_lba: assert property (s_bad_word |=>
		cmd_done && ata_lba_out == $past(media_lba)) else $error("fail lba wrong");
	chk_fail_status: assert property (s_bad_word |=>
		(ata_status & (STAT_ERR | STAT_SENSE)) == (STAT_ERR | STAT_SENSE) &&
		ata_status[5] == $past(media_fault)) else $error("fail status wrong");
	chk_stop_at_fail: assert property (s_bad_word |=>
		(!media_req && idle) [*2] ##0 !xfer_valid) else $error("transfer went on");
endmodule // ard_top
`default_nettype wire

// [hw/ard_pkg.sv]
// ard_pkg: constants and types shared by the read-command decoder files
// assumes: one 10 MHz clock domain, AXI4-Lite register access
`default_nettype none
package ard_pkg;
	// command opcodes
	localparam logic [7:0] OP_LOG_DMA = 8'h47;
	localparam logic [7:0] OP_RDMUL = 8'hC4;
	localparam logic [7:0] OP_RDMUL_EXT = 8'h29;
	// vendor log page layout
	localparam logic [7:0] LOG_ADDR_NAND = 8'hD9;
	localparam logic [15:0] LOG_PAGE_LEN = 16'h0200;
	localparam logic [15:0] LOG_PAGE_ONLY = 16'h0000;
	localparam logic [15:0] LOG_BLOCKS = 16'h0001;
	localparam logic [8:0] LOG_BYTE_CODE = 9'h001;
	localparam logic [8:0] LOG_BYTE_LEN_LO = 9'h002;
	localparam logic [8:0] LOG_BYTE_LEN_HI = 9'h003;
	localparam logic [8:0] LOG_BYTE_FLAGS = 9'h004;
	localparam logic [8:0] LOG_BYTE_FW_FIRST = 9'h010;
	localparam logic [8:0] LOG_BYTE_FW_LAST = 9'h01F;
	localparam int FLAG_NVC_BIT = 0;
	// log-read address field positions
	localparam int LBA_LOGSEL_LSB = 0;
	localparam int LBA_PGLO_LSB = 8;
	localparam int LBA_PGHI_LSB = 32;
	localparam int LBA28_W = 28;
	// sector counts
	localparam logic [16:0] SECT28_ZERO = 17'h00100;
	localparam logic [16:0] SECT48_ZERO = 17'h10000;
	localparam logic [7:0] WORD_LAST = 8'hFF;
	// status and error masks
	localparam logic [7:0] STAT_BSY = 8'h80;
	localparam logic [7:0] STAT_RDY = 8'h40;
	localparam logic [7:0] STAT_DF = 8'h20;
	localparam logic [7:0] STAT_DRQ = 8'h08;
	localparam logic [7:0] STAT_SENSE = 8'h02;
	localparam logic [7:0] STAT_ERR = 8'h01;
	localparam logic [7:0] ERR_UNC = 8'h40;
	localparam logic [7:0] ERR_ABRT = 8'h04;
	localparam logic [7:0] STAT_RST = 8'h40;
	// register map, byte addresses
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_MULT = 8'h04;
	localparam logic [7:0] REG_STATE = 8'h08;
	localparam logic [7:0] REG_LASTERR = 8'h0C;
	localparam logic [7:0] REG_FW0 = 8'h10;
	localparam logic [7:0] REG_IRQ_STAT = 8'h20;
	localparam logic [7:0] REG_IRQ_MASK = 8'h24;
	localparam logic [7:0] MULT_RST = 8'h00;
	localparam logic [127:0] FW_RST = 128'h0;
	// interrupt bits
	localparam int IRQ_W = 3;
	localparam int IRQ_BLOCK = 0;
	localparam int IRQ_DONE = 1;
	localparam int IRQ_FAIL = 2;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_LOG = 2'b01,
		ST_SECT = 2'b10
	} ard_state_t;
endpackage
`default_nettype wire

// [hw/ard_reg_if.sv]
// ard_reg_if: register access strobes between bus slave and register file
// assumes: both ends on aclk; read data is combinational from the file
`timescale 1ns/1ps
`default_nettype none
interface ard_reg_if;
	logic wr_en;
	logic [7:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic wr_err;
	logic rd_en;
	logic [7:0] rd_addr;
	logic [31:0] rd_data;
	logic rd_err;
	modport master(output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
		input wr_err, rd_data, rd_err);
	modport regs(input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
		output wr_err, rd_data, rd_err);
endinterface
`default_nettype wire

// [hw/ard_axil_slave.sv]
// ard_axil_slave: AXI4-Lite slave, one write and one read in flight
// assumes: register file answers wr_err, rd_data, rd_err in the same cycle
`timescale 1ns/1ps
`default_nettype none
module ard_axil_slave import ard_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [7:0] s_axi_araddr,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	ard_reg_if.master rb
);
	logic aw_have;
	logic w_have;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	wire aw_fire = s_axi_awvalid && s_axi_awready;
	wire w_fire = s_axi_wvalid && s_axi_wready;
	wire ar_fire = s_axi_arvalid && s_axi_arready;
	wire wr_go = aw_have && w_have && !s_axi_bvalid;
	wire next_aw_have = (aw_have && !wr_go) || aw_fire;
	wire next_w_have = (w_have && !wr_go) || w_fire;
	wire next_bvalid = wr_go || (s_axi_bvalid && !s_axi_bready);
	wire next_rvalid = ar_fire || (s_axi_rvalid && !s_axi_rready);
	assign rb.wr_en = wr_go;
	assign rb.wr_addr = aw_addr;
	assign rb.wr_data = w_data;
	assign rb.wr_strb = w_strb;
	assign rb.rd_en = ar_fire;
	assign rb.rd_addr = s_axi_araddr;
	// ready stays low until the response is taken: one write at a time
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have <= 1'b0;
			w_have <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			aw_have <= next_aw_have;
			w_have <= next_w_have;
			s_axi_awready <= !next_aw_have && !next_bvalid;
			s_axi_wready <= !next_w_have && !next_bvalid;
			s_axi_bvalid <= next_bvalid;
			if (wr_go) begin
				s_axi_bresp <= rb.wr_err ? RESP_SLVERR : RESP_OKAY;
			end
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_addr <= 8'h00;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
		end else begin
			if (aw_fire) begin
				aw_addr <= s_axi_awaddr;
			end
			if (w_fire) begin
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end else begin
			s_axi_arready <= !next_rvalid;
			s_axi_rvalid <= next_rvalid;
			if (ar_fire) begin
				s_axi_rdata <= rb.rd_data;
				s_axi_rresp <= rb.rd_err ? RESP_SLVERR : RESP_OKAY;
			end
		end
	end
endmodule // ard_axil_slave
`default_nettype wire

// [testbench/ard_media_model.sv]
// ard_media_model: sector word source on the media side of the decoder
// assumes: a word is taken in the cycle media_valid is high; bad of 1FFFFh means none
`timescale 1ns/1ps
`default_nettype none
module ard_media_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic media_req,
	input wire logic [47:0] media_lba,
	input wire logic [15:0] gap,
	input wire logic [16:0] bad,
	input wire logic flt,
	output logic media_valid,
	output logic [15:0] media_word,
	output logic media_uncorr,
	output logic media_fault
);
	logic [15:0] wt;
	logic [16:0] n;
	always_ff @(posedge aclk) begin
		// idle data keeps changing so a stale word is never mistaken for a good one
		media_word <= ~media_word;
		media_valid <= 1'b0;
		media_uncorr <= 1'b0;
		media_fault <= 1'b0;
		if (!aresetn || !media_req) begin
			wt <= gap;
			n <= 17'h00000;
			if (!aresetn) media_word <= 16'h5A5A;
		end else if (media_valid) begin
			wt <= gap;
			n <= n + 17'h00001;
		end else if (wt != 16'h0000) begin
			wt <= wt - 16'h0001;
		end else begin
			media_valid <= 1'b1;
			media_word <= {media_lba[7:0], n[7:0]};
			media_uncorr <= (n == bad);
			media_fault <= flt && (n == bad);
		end
	end
endmodule // ard_media_model
`default_nettype wire

// [testbench/tb_ata_read_command_decoder.sv]
// tb_ata_read_command_decoder: self-checking bench for ard_top
// assumes: ard_pkg compiled first; media side played by ard_media_model
`timescale 1ns/1ps
`default_nettype none
module tb_ata_read_command_decoder;
	import ard_pkg::*;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0] s_axi_awaddr, s_axi_araddr, host_cmd_op, ata_status, ata_error;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	logic host_cmd_valid, media_valid, media_uncorr, media_fault, media_req;
	logic xfer_valid, xfer_dma, cmd_done, irq, flt;
	logic [15:0] host_cmd_count, media_word, xfer_word, gap;
	logic [47:0] host_cmd_lba, media_lba, ata_lba_out;
	logic [16:0] bad;
	logic [16:0] got[$];
	logic [7:0] lb[512];
	int bad_count, samples_checked;
	int cyc = 0;
	typedef struct {logic [7:0] op; logic [15:0] c; logic [47:0] l; logic [7:0] e;} ard_row_t;
	ard_row_t rows[7] = '{
		'{8'h20, 16'h0001, 48'h0000_0000_0000, ERR_ABRT},
		'{OP_LOG_DMA, 16'h0001, 48'h0000_0000_00D8, ERR_ABRT},
		'{OP_LOG_DMA, 16'h0001, 48'h0000_0000_01D9, ERR_ABRT},
		'{OP_LOG_DMA, 16'h0001, 48'h0001_0000_00D9, ERR_ABRT},
		'{OP_LOG_DMA, 16'h0002, 48'h0000_0000_00D9, ERR_ABRT},
		'{OP_RDMUL, 16'h0001, 48'h0000_0000_0000, ERR_ABRT},
		'{OP_RDMUL_EXT, 16'h0001, 48'h0000_0000_0000, ERR_ABRT}
	};
	ard_top uut (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
		.s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
		.s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
		.s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .host_cmd_valid,
		.host_cmd_op, .host_cmd_count, .host_cmd_lba, .media_valid, .media_word,
		.media_uncorr, .media_fault, .media_req, .media_lba, .xfer_valid, .xfer_word,
		.xfer_dma, .cmd_done, .ata_status, .ata_error, .ata_lba_out, .irq);
	ard_media_model mm (.aclk, .aresetn, .media_req, .media_lba, .gap, .bad, .flt,
		.media_valid, .media_word, .media_uncorr, .media_fault);
	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (xfer_valid === 1'b1) got.push_back({xfer_dma, xfer_word});
		if (cyc == 40000) begin
			bad_count++;
			close_out();
		end
	end
	task close_out;
		$display("checked %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task cmp(input string nm, input logic [47:0] e, input logic [47:0] g);
		samples_checked++;
		if (g !== e) begin
			bad_count++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic ta, tw;
		ta = 1'b0;
		tw = 1'b0;
		@(posedge aclk);
		s_axi_awvalid <= 1'b1;
		s_axi_awaddr <= a;
		s_axi_wvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hF;
		s_axi_bready <= 1'b1;
		while (!(ta && tw)) begin
			@(negedge aclk);
			ta = ta | (s_axi_awready === 1'b1);
			tw = tw | (s_axi_wready === 1'b1);
			@(posedge aclk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
		end
		do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
		resp = s_axi_bresp;
		@(posedge aclk);
		s_axi_bready <= 1'b0;
	endtask
	task rdr(input logic [7:0] a);
		@(posedge aclk);
		s_axi_arvalid <= 1'b1;
		s_axi_araddr <= a;
		s_axi_rready <= 1'b1;
		do @(negedge aclk); while (s_axi_arready !== 1'b1);
		@(posedge aclk);
		s_axi_arvalid <= 1'b0;
		do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
		rd = s_axi_rdata;
		resp = s_axi_rresp;
		@(posedge aclk);
		s_axi_rready <= 1'b0;
	endtask
	task cmd(input logic [7:0] o, input logic [15:0] c, input logic [47:0] l);
		@(posedge aclk);
		host_cmd_valid <= 1'b1;
		host_cmd_op <= o;
		host_cmd_count <= c;
		host_cmd_lba <= l;
		@(posedge aclk);
		host_cmd_valid <= 1'b0;
	endtask
	task wdone;
		for (int i = 0; i < 20000 && cmd_done !== 1'b1; i++) @(negedge aclk);
		cmp("cmd_done", 48'h1, {47'h0, cmd_done});
		@(negedge aclk);
	endtask
	// failing read: words stop at the bad word, whose sector is reported
	task fail(input logic [7:0] o, input logic [47:0] l, input logic [16:0] b,
		input logic f, input logic [16:0] n);
		bad <= b;
		flt <= f;
		gap <= 16'h001E;
		got.delete();
		cmd(o, 16'h0000, l);
		rdr(REG_STATE);
		cmp("sect_left", {31'h0, n}, {31'h0, rd[24:8]});
		cmp("state", {46'h0, ST_SECT}, {46'h0, rd[1:0]});
		cmp("busy_status", {40'h0, STAT_BSY | STAT_DRQ}, {40'h0, ata_status});
		wdone();
		cmp("words", {31'h0, b}, 48'(got.size()));
		cmp("ata_status", {40'h0, STAT_RDY | STAT_SENSE | STAT_ERR | (f ? STAT_DF : 8'h00)},
			{40'h0, ata_status});
		cmp("ata_error", {40'h0, ERR_UNC}, {40'h0, ata_error});
		cmp("lba_out", l + 48'(b / 17'h00100), ata_lba_out);
		cmp("media_req", 48'h0, {47'h0, media_req});
	endtask
	initial begin
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{host_cmd_valid, flt, s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
		{host_cmd_op, host_cmd_count, host_cmd_lba, gap} = '0;
		bad = 17'h1FFFF;
		bad_count = 0;
		samples_checked = 0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(negedge aclk);
		cmp("ata_status", {40'h0, STAT_RST}, {40'h0, ata_status});
		foreach (rows[i]) begin
			cmd(rows[i].op, rows[i].c, rows[i].l);
			wdone();
			cmp("ata_error", {40'h0, rows[i].e}, {40'h0, ata_error});
		end
		wr(REG_CTRL, 32'h0000_0001);
		cmp("bresp", {46'h0, RESP_OKAY}, {46'h0, resp});
		lb = '{default: 8'h00};
		lb[1] = LOG_ADDR_NAND;
		lb[3] = 8'h02;
		lb[4] = 8'h01;
		for (int i = 0; i < 4; i++) wr(8'(REG_FW0 + 4 * i), 32'hA0B1C2D3 ^ (i * 32'h01010101));
		for (int j = 0; j < 16; j++)
			lb[16 + j] = 8'((32'hA0B1C2D3 ^ ((j / 4) * 32'h01010101)) >> (8 * (j % 4)));
		wr(REG_IRQ_MASK, 32'h0000_0007);
		got.delete();
		cmd(OP_LOG_DMA, 16'h0001, 48'h0000_0000_00D9);
		wdone();
		cmp("log_words", 48'h100, 48'(got.size()));
		for (int w = 0; w < 256; w++)
			cmp("log_word", {32'h1, lb[2 * w + 1], lb[2 * w]}, {31'h0, got[w]});
		wr(REG_MULT, 32'h0000_0001);
		wr(REG_IRQ_STAT, 32'h0000_0007);
		got.delete();
		cmd(OP_RDMUL, 16'h0002, 48'h0000_0123_4567);
		wdone();
		cmp("mul_words", 48'h200, 48'(got.size()));
		for (int w = 0; w < 512; w++)
			cmp("mul_word", {32'h0, 8'(32'h67 + w / 256), 8'(w)}, {31'h0, got[w]});
		cmp("ata_status", {40'h0, STAT_RDY}, {40'h0, ata_status});
		rdr(REG_IRQ_STAT);
		cmp("irq_stat", 48'h3, {16'h0, rd});
		cmp("irq", 48'h1, {47'h0, irq});
		wr(REG_IRQ_STAT, 32'h0000_0003);
		rdr(REG_IRQ_STAT);
		cmp("irq_stat", 48'h0, {16'h0, rd});
		repeat (2) @(negedge aclk);
		cmp("irq", 48'h0, {47'h0, irq});
		rdr(8'h40);
		cmp("rresp", {46'h0, RESP_SLVERR}, {46'h0, resp});
		wr(8'h40, 32'h0000_0001);
		cmp("bresp", {46'h0, RESP_SLVERR}, {46'h0, resp});
		fail(OP_RDMUL, 48'h0000_0ABC_DEF0, 17'h00000, 1'b0, SECT28_ZERO);
		fail(OP_RDMUL_EXT, 48'hA5A5_1234_5678, 17'h0012C, 1'b1, SECT48_ZERO);
		// reset in mid transfer, with irq and MULT set: all back to idle values
		bad <= 17'h1FFFF;
		cmd(OP_RDMUL_EXT, 16'h0004, 48'h0000_0000_0000);
		repeat (40) @(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(negedge aclk);
		cmp("rst_media_req", 48'h0, {47'h0, media_req});
		cmp("rst_status", {40'h0, STAT_RST}, {40'h0, ata_status});
		cmp("rst_irq", 48'h0, {47'h0, irq});
		rdr(REG_MULT);
		cmp("rst_mult", {40'h0, MULT_RST}, {16'h0, rd});
		close_out();
	end
endmodule // tb_ata_read_command_decoder
`default_nettype wire
